// [hdl/asc_ctrl.sv]
// Purpose: Host controller driving a 256K x 16 asynchronous static memory.
// Assumes: 40 MHz clock, memory of the fastest speed grade or faster.
//   The data bus pins are split into an output, an enable and an input at the pad.
// Notes: One access at a time; request is taken only when ready is high.
//   A write takes four cycles and a read six, well above the memory's own cycle time.
//   Reset leaves stored data alone, since the memory itself has no reset.

`timescale 1ns/1ps
`default_nettype none

module asc_ctrl (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,

  // User request
  input wire logic i_req,
  input wire logic i_wr,
  input wire logic [asc_pkg::ASC_ADDR_W-1:0] i_addr,
  input wire logic [asc_pkg::ASC_DATA_W-1:0] i_wdata,
  input wire logic [1:0] i_lane_en,
  output logic o_ready,
  output logic o_rvalid,
  output logic [asc_pkg::ASC_DATA_W-1:0] o_rdata,

  // Memory pins
  output logic [asc_pkg::ASC_ADDR_W-1:0] o_word_address,
  output logic o_chip_select_n,
  output logic o_write_enable_n,
  output logic o_output_enable_n,
  output logic o_lower_lane_enable_n,
  output logic o_upper_lane_enable_n,
  output logic [asc_pkg::ASC_DATA_W-1:0] o_data_bus,
  output logic o_data_bus_oe,
  input wire logic [asc_pkg::ASC_DATA_W-1:0] i_data_bus
);
  import asc_pkg::*;

  typedef struct packed {
    asc_state_t st;
    logic [ASC_CNT_W-1:0] cnt;
    logic wr;
    logic [1:0] lane;
    logic ready;
    logic rvalid;
    logic [ASC_DATA_W-1:0] rdata;
    logic [ASC_ADDR_W-1:0] addr;
    logic cs_n;
    logic we_n;
    logic oe_n;
    logic lle_n;
    logic ule_n;
    logic [ASC_DATA_W-1:0] dout;
    logic doe;
  } asc_ctrl_st_t;

  // Every strobe rests high, so a reset leaves the memory deselected with its pins floating.
  localparam asc_ctrl_st_t ASC_CTRL_RST = '{
    st: ASC_IDLE,
    cnt: ASC_CNT_ZERO,
    wr: 1'b0,
    lane: 2'h0,
    ready: 1'b1,
    rvalid: 1'b0,
    rdata: '0,
    addr: '0,
    cs_n: 1'b1,
    we_n: 1'b1,
    oe_n: 1'b1,
    lle_n: 1'b1,
    ule_n: 1'b1,
    dout: '0,
    doe: 1'b0
  };

  asc_ctrl_st_t s_r;
  asc_ctrl_st_t s_nxt;
  logic [ASC_DATA_W-1:0] din_sync;
  wire logic take;
  wire logic [ASC_DATA_W-1:0] lane_rd;
  wire logic [1:0] lane_off_n;

  // The bus input is sampled after two stages; reads wait for it.
  asc_sync u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_d(i_data_bus),
    .o_q(din_sync)
  );

  // A request with no lane enabled is dropped, as it could move no data.
  assign take = i_req && s_r.ready && (i_lane_en != 2'h0);

  // Disabled lanes read as zero so an undriven byte never reaches the user.
  for (genvar g = 0; g < ASC_DATA_W / ASC_LANE_W; g++) begin : g_lane
    assign lane_off_n[g] = ~s_r.lane[g];
    assign lane_rd[g*ASC_LANE_W +: ASC_LANE_W] = s_r.lane[g] ? din_sync[g*ASC_LANE_W +: ASC_LANE_W] : '0;
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;

    unique case (s_r.st)
      ASC_IDLE: begin
        if (take) begin
          // Address and data are set first; strobes follow a cycle later.
          s_nxt.addr = i_addr;
          s_nxt.wr = i_wr;
          s_nxt.lane = i_lane_en;
          s_nxt.dout = i_wdata;
          s_nxt.ready = 1'b0;
          s_nxt.oe_n = 1'b1;
          s_nxt.st = ASC_SETUP;
        end
      end

      ASC_SETUP: begin
        // Select and lane enables fall with write enable on a write, keeping the memory's outputs off, or with output enable on a read.
        s_nxt.cs_n = 1'b0;
        s_nxt.lle_n = lane_off_n[0];
        s_nxt.ule_n = lane_off_n[1];

        if (s_r.wr) begin
          s_nxt.we_n = 1'b0;
          s_nxt.doe = 1'b1;
          s_nxt.cnt = ASC_WP_CYC;
        end else begin
          s_nxt.oe_n = 1'b0;
          // Two extra cycles cover the synchroniser, so the sampled word has settled.
          s_nxt.cnt = ASC_RD_CYC + ASC_CNT_ONE + ASC_CNT_ONE;
        end
        s_nxt.st = ASC_ACT;
      end

      ASC_ACT: begin
        if (s_r.cnt > ASC_CNT_ONE) begin
          s_nxt.cnt = s_r.cnt - ASC_CNT_ONE;
        end else begin
          if (s_r.wr) begin
            s_nxt.we_n = 1'b1;
          end else begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = lane_rd;
            s_nxt.oe_n = 1'b1;
          end

          // Address and data stay put as the strobes rise, which gives the memory its zero hold.
          s_nxt.cs_n = 1'b1;
          s_nxt.lle_n = 1'b1;
          s_nxt.ule_n = 1'b1;
          s_nxt.cnt = ASC_TA_CYC > ASC_CY_CYC ? ASC_TA_CYC : ASC_CY_CYC;
          s_nxt.st = ASC_TURN;
        end
      end

      ASC_TURN: begin
        // Write data is held one cycle past write enable rising.
        s_nxt.doe = 1'b0;

        if (s_r.cnt > ASC_CNT_ONE) begin
          s_nxt.cnt = s_r.cnt - ASC_CNT_ONE;
        end else begin
          s_nxt.cnt = ASC_CNT_ZERO;
          // Ready returns only once the controller has let go of the data bus.
          s_nxt.ready = 1'b1;
          s_nxt.st = ASC_IDLE;
        end
      end

      default: begin
        s_nxt.st = ASC_IDLE;
      end
    endcase
  end

  // Reset is synchronous and never touches the memory's contents.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s_r <= ASC_CTRL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Every output is a register bit, so no glitch reaches the memory pins.
  assign o_ready = s_r.ready;
  assign o_rvalid = s_r.rvalid;
  assign o_rdata = s_r.rdata;

  assign o_word_address = s_r.addr;
  assign o_chip_select_n = s_r.cs_n;
  assign o_write_enable_n = s_r.we_n;
  assign o_output_enable_n = s_r.oe_n;
  assign o_lower_lane_enable_n = s_r.lle_n;
  assign o_upper_lane_enable_n = s_r.ule_n;
  assign o_data_bus = s_r.dout;
  assign o_data_bus_oe = s_r.doe;

endmodule
`default_nettype wire

// [hdl/asc_pkg.sv]
// Purpose: Constants for the asynchronous static memory controller.
// Assumes: 40 MHz controller clock, fastest memory speed grade.
// Notes: Times are in picoseconds; cycle counts derive from the clock period.
package asc_pkg;
  localparam int ASC_ADDR_W = 18;
  localparam int ASC_DATA_W = 16;
  localparam int ASC_LANE_W = 8;
  localparam int ASC_CLK_PS = 25000;
  localparam int ASC_TWC_PS = 10000;
  localparam int ASC_TWP_PS = 8000;
  localparam int ASC_TWHZ_PS = 6000;
  localparam int ASC_TDW_PS = 5000;
  localparam int ASC_TAA_PS = 10000;
  localparam int ASC_TOHZ_PS = 5000;
  localparam int ASC_TOW_PS = 3000;
  localparam int ASC_CNT_W = 4;
  // Least times round up to whole clock cycles.
  localparam int ASC_WP_RAW = (ASC_TWHZ_PS + ASC_TDW_PS + ASC_CLK_PS - 1) / ASC_CLK_PS;
  localparam int ASC_RD_RAW = (ASC_TAA_PS + ASC_CLK_PS - 1) / ASC_CLK_PS;
  localparam int ASC_TA_RAW = (ASC_TOHZ_PS + ASC_TOW_PS + ASC_CLK_PS - 1) / ASC_CLK_PS;
  localparam int ASC_CY_RAW = (ASC_TWC_PS + ASC_CLK_PS - 1) / ASC_CLK_PS;
  localparam logic [ASC_CNT_W-1:0] ASC_WP_CYC = ASC_CNT_W'(ASC_WP_RAW < 1 ? 1 : ASC_WP_RAW);
  localparam logic [ASC_CNT_W-1:0] ASC_RD_CYC = ASC_CNT_W'(ASC_RD_RAW < 1 ? 1 : ASC_RD_RAW);
  localparam logic [ASC_CNT_W-1:0] ASC_TA_CYC = ASC_CNT_W'(ASC_TA_RAW < 1 ? 1 : ASC_TA_RAW);
  localparam logic [ASC_CNT_W-1:0] ASC_CY_CYC = ASC_CNT_W'(ASC_CY_RAW < 1 ? 1 : ASC_CY_RAW);
  localparam logic [ASC_CNT_W-1:0] ASC_CNT_ZERO = 4'h0;
  localparam logic [ASC_CNT_W-1:0] ASC_CNT_ONE = 4'h1;
  typedef enum logic [2:0] {
    ASC_IDLE = 3'h0,
    ASC_SETUP = 3'h1,
    ASC_ACT = 3'h3,
    ASC_TURN = 3'h2
  } asc_state_t;
endpackage

// [hdl/asc_sync.sv]
// Purpose: Two-stage synchroniser for the memory data bus inputs.
// Assumes: One clock domain.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ps
`default_nettype none
module asc_sync (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Data
  input wire logic [asc_pkg::ASC_DATA_W-1:0] i_d,
  output logic [asc_pkg::ASC_DATA_W-1:0] o_q
);
  import asc_pkg::*;
  typedef struct packed {
    logic [ASC_DATA_W-1:0] s1;
    logic [ASC_DATA_W-1:0] s2;
  } asc_sync_st_t;
  asc_sync_st_t st_r;
  asc_sync_st_t st_nxt;
  always_comb begin
    st_nxt.s1 = i_d;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign o_q = st_r.s2;
endmodule
`default_nettype wire

// [verification/asc_ctrl_sva.sv]
// Purpose: Pin protocol checks on the static memory controller.
// Assumes: One clock, synchronous active-high reset.
// Notes: Ports are grouped by width to stay compact.
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl_sva (
  input wire logic i_mclk, i_rst, i_req, i_wr, o_ready, o_rvalid, o_data_bus_oe,
  input wire logic o_chip_select_n, o_write_enable_n, o_output_enable_n,
  input wire logic o_lower_lane_enable_n, o_upper_lane_enable_n,
  input wire logic [1:0] i_lane_en,
  input wire logic [17:0] i_addr, o_word_address,
  input wire logic [15:0] i_wdata, o_rdata, o_data_bus, i_data_bus
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence take_s(bit w);
    i_req && o_ready && i_lane_en != 2'h0 && i_wr == w;
  endsequence
  sequence wr_pulse_s;
    !o_write_enable_n ##1 o_write_enable_n;
  endsequence
  a_no_bus_fight: assert property (o_data_bus_oe |-> o_output_enable_n)
    else $error("Controller drives data while memory outputs are on.");
  a_write_data_on: assert property (!o_write_enable_n |-> o_output_enable_n && o_data_bus_oe)
    else $error("Write pulse without driven data or with outputs on.");
  a_write_select: assert property (!o_write_enable_n |-> !o_chip_select_n && !(o_lower_lane_enable_n && o_upper_lane_enable_n))
    else $error("Write pulse outside select and lane enable.");
  a_addr_stable: assert property (!o_chip_select_n |-> $stable(o_word_address))
    else $error("Address moved while selected.");
  a_write_cycle: assert property (take_s(1'b1) |=> !o_ready ##[0:2] wr_pulse_s ##[0:3] o_ready)
    else $error("Write cycle shape wrong.");
  a_read_answer: assert property (take_s(1'b0) |=> !o_ready ##[2:6] o_rvalid ##[0:2] o_ready)
    else $error("Read answer out of time.");
  a_read_no_write: assert property (take_s(1'b0) |=> o_write_enable_n [*6])
    else $error("Write enable low during a read.");
  a_idle_deselect: assert property (o_ready && !o_rvalid |-> o_chip_select_n && !o_data_bus_oe)
    else $error("Memory selected or bus driven while idle.");
endmodule
bind asc_ctrl asc_ctrl_sva u_sva (.i_mclk, .i_rst, .i_req, .i_wr, .o_ready, .o_rvalid, .o_data_bus_oe,
  .o_chip_select_n, .o_write_enable_n, .o_output_enable_n, .o_lower_lane_enable_n, .o_upper_lane_enable_n,
  .i_lane_en, .i_addr, .o_word_address, .i_wdata, .o_rdata, .o_data_bus, .i_data_bus);
`default_nettype wire

// [verification/asc_mem_model.sv]
// Purpose: Behavioural asynchronous 256K x 16 static memory.
// Assumes: DLY covers access and release times of the fastest grade.
// Notes: A released lane shows the inverted byte, so a missed drive never reads as data.
`timescale 1ns/1ps
`default_nettype none
module asc_mem_model #(parameter int DLY = 4) (
  input wire logic [17:0] i_a,
  input wire logic i_cs_n, i_we_n, i_oe_n, i_le_n, i_ue_n,
  input wire logic [15:0] i_d,
  output logic [15:0] o_q
);
  logic [15:0] mem [0:262143];
  wire rd = !i_cs_n && i_we_n && !i_oe_n;
  always @* if (!i_cs_n && !i_we_n) begin
    if (!i_le_n) mem[i_a][7:0] = i_d[7:0];
    if (!i_ue_n) mem[i_a][15:8] = i_d[15:8];
  end
  // Four units keep the old word for the hold time yet meet every access limit.
  assign #DLY o_q = {(rd && !i_ue_n) ? mem[i_a][15:8] : ~mem[i_a][15:8],
    (rd && !i_le_n) ? mem[i_a][7:0] : ~mem[i_a][7:0]};
endmodule
`default_nettype wire

// [verification/asc_ctrl_bench.sv]
// Purpose: Self-checking bench for the static memory controller.
// Assumes: Behavioural memory on the far side of the pins.
// Notes: Table rows run back to back; a held request checks refusal while busy.
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl_bench;
  typedef struct packed {logic w; logic [17:0] a; logic [15:0] d; logic [1:0] l; logic h; logic [15:0] e;} asc_row_t;
  asc_row_t rows [13] = '{'{1'b1, 18'h3ffff, 16'ha5c3, 2'h3, 1'b0, 16'h0},
    '{1'b1, 18'h0, 16'h1234, 2'h3, 1'b0, 16'h0}, '{1'b1, 18'h3ffff, 16'h7e11, 2'h2, 1'b0, 16'h0},
    '{1'b0, 18'h3ffff, 16'h0, 2'h3, 1'b0, 16'h7ec3}, '{1'b0, 18'h3ffff, 16'h0, 2'h1, 1'b0, 16'h00c3},
    '{1'b0, 18'h0, 16'h0, 2'h2, 1'b0, 16'h1200}, '{1'b1, 18'h0, 16'hbeef, 2'h1, 1'b0, 16'h0},
    '{1'b0, 18'h0, 16'h0, 2'h3, 1'b0, 16'h12ef}, '{1'b1, 18'h0, 16'hffff, 2'h0, 1'b0, 16'h0},
    '{1'b0, 18'h0, 16'h0, 2'h3, 1'b0, 16'h12ef}, '{1'b1, 18'h1, 16'h0, 2'h3, 1'b1, 16'h0},
    '{1'b0, 18'h1, 16'h0, 2'h3, 1'b0, 16'h0}, '{1'b0, 18'h1, 16'h0, 2'h1, 1'b0, 16'h0}};
  logic i_mclk = 1'b0, i_rst = 1'b1, i_req = 1'b0, i_wr = 1'b0;
  logic [17:0] i_addr = 18'h0, o_word_address;
  logic [15:0] i_wdata = 16'h0, rd, o_rdata, o_data_bus, i_data_bus, mq;
  logic [1:0] i_lane_en = 2'h0;
  logic o_ready, o_rvalid, o_chip_select_n, o_write_enable_n, o_output_enable_n;
  logic o_lower_lane_enable_n, o_upper_lane_enable_n, o_data_bus_oe;
  int n_mismatch = 0, check_count = 0;
  assign i_data_bus = o_data_bus_oe ? o_data_bus : mq;
  asc_ctrl dut (.i_mclk, .i_rst, .i_req, .i_wr, .i_addr, .i_wdata, .i_lane_en, .o_ready, .o_rvalid, .o_rdata,
    .o_word_address, .o_chip_select_n, .o_write_enable_n, .o_output_enable_n, .o_lower_lane_enable_n,
    .o_upper_lane_enable_n, .o_data_bus, .o_data_bus_oe, .i_data_bus);
  asc_mem_model #(.DLY(4)) u_mem (.i_a(o_word_address), .i_cs_n(o_chip_select_n), .i_we_n(o_write_enable_n),
    .i_oe_n(o_output_enable_n), .i_le_n(o_lower_lane_enable_n), .i_ue_n(o_upper_lane_enable_n),
    .i_d(i_data_bus), .o_q(mq));
  initial begin
    forever #12.5 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // A held request stays up while busy and must be ignored; the next row's request replaces it.
  task automatic op(input asc_row_t r);
    {i_req, i_wr, i_addr, i_wdata, i_lane_en, rd} = {1'b1, r.w, r.a, r.d, r.l, 16'hxxxx};
    @(posedge i_mclk) #1;
    i_req = r.h;
    i_wdata = ~r.d;
    repeat (20) begin
      if (o_rvalid === 1'b1) rd = o_rdata;
      if (o_ready !== 1'b1) @(posedge i_mclk) #1;
    end
  endtask
  initial begin
    repeat (5) @(posedge i_mclk);
    #1 i_rst = 1'b0;
    chk({15'h0, o_data_bus_oe}, 16'h0);
    foreach (rows[k]) begin
      op(rows[k]);
      if (!rows[k].w) chk(rd, rows[k].e);
    end
    {i_req, i_wr, i_addr, i_wdata, i_lane_en} = {1'b1, 1'b1, 18'h3ffff, 16'h0, 2'h3};
    // Reset lands while the write is still in setup, so no strobe reaches the memory.
    @(posedge i_mclk) #1;
    i_req = 1'b0;
    i_rst = 1'b1;
    @(posedge i_mclk) #1 i_rst = 1'b0;
    chk({12'h0, o_ready, o_chip_select_n, o_write_enable_n, o_data_bus_oe}, 16'h000e);
    chk({12'h0, o_rvalid, o_output_enable_n, o_lower_lane_enable_n, o_upper_lane_enable_n}, 16'h0007);
    op(rows[3]);
    chk(rd, 16'h7ec3);
    report_and_stop();
  end
  initial begin
    #20us;
    n_mismatch++;
    report_and_stop();
  end
endmodule
`default_nettype wire
